// ==== rtl/lam_consts.vh ====
// constants and register map of the line alarm monitor
`ifndef LAM_CONSTS_VH
`define LAM_CONSTS_VH
`define LAM_ADDR_CR1 6'h10
`define LAM_ADDR_CR2 6'h11
`define LAM_ADDR_CR3 6'h12
`define LAM_ADDR_ICR 6'h13
`define LAM_ADDR_TSR 6'h14
`define LAM_ADDR_PSR 6'h15
`define LAM_ADDR_CR4 6'h17
`define LAM_REG_RESET 8'h00
`define LAM_CR1_EC_LSB 0
`define LAM_CR1_ENC_BIT 5
`define LAM_CR3_BIST_BIT 5
`define LAM_CR4_CODE_VIOLATION_DETECT_BIT 0
`define LAM_CR4_ZERO_SUBSTITUTION_VIOLATION_DETECT_BIT 1
`define LAM_CR4_LONG_BIT 2
`define LAM_CR4_MARKS_BIT 3
`define LAM_BIT_LOS 0
`define LAM_BIT_AIS 2
`define LAM_BIT_PAT 3
`define LAM_BIT_DFO 5
`define LAM_BIT_BIST 6
`define LAM_BIT_ESO 6
`define LAM_BIT_ESU 7
`define LAM_EC_E1 3'h0
`define LAM_LOS_T1 12'd175
`define LAM_LOS_E1 12'd32
`define LAM_LOS_LONG 12'd2048
`define LAM_T1_WIN 128
`define LAM_T1_MARKS 8'd16
`define LAM_T1_RUN 12'd100
`define LAM_E1_WIN 32
`define LAM_E1_MARKS 8'd4
`define LAM_E1_RUN 12'd16
`define LAM_CM_COUNT 6'd32
`define LAM_AIS_SPAN 12'd2047
`define LAM_AIS_ZEROS 2'd3
`define LAM_ZS_RUN 3'd4
`endif

// ==== rtl/lam_line_alarm_monitor.v ====
// line alarm monitor: violation detectors, loss, AIS, status and interrupt registers
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lam_consts.vh"
module lam_line_alarm_monitor (
  input wire CLK,
  input wire RESETN,
  input wire [5:0] ADDR,
  input wire RD_FLAG,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire RX_BIT_EN,
  input wire RECEIVE_POSITIVE_DATA,
  input wire RECEIVE_NEGATIVE_DATA,
  input wire DRIVER_OPEN_IN,
  input wire ES_NEAR_OVER_IN,
  input wire ES_NEAR_UNDER_IN,
  input wire ES_OVER_IN,
  input wire ES_UNDER_IN,
  input wire PATTERN_LOCK_IN,
  output reg LINE_VIOLATION_OUTPUT,
  output reg RX_DATA_POS,
  output reg RX_DATA_NEG,
  output reg CLOCK_SEL_MASTER,
  output reg [1:0] ES_PHASE_ADJ,
  output reg INT_N,
  output reg SELF_TEST_ON
);
  // receive side arrives as pins: two-flop synchronisers
  localparam NSYNC = 9;
  reg [NSYNC-1:0] s1_reg;
  reg [NSYNC-1:0] s2_reg;
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s1_reg <= {NSYNC{1'b0}};
      s2_reg <= {NSYNC{1'b0}};
    end else begin
      s1_reg <= {RX_BIT_EN, RECEIVE_POSITIVE_DATA, RECEIVE_NEGATIVE_DATA, DRIVER_OPEN_IN,
                 ES_NEAR_OVER_IN, ES_NEAR_UNDER_IN, ES_OVER_IN, ES_UNDER_IN, PATTERN_LOCK_IN};
      s2_reg <= s1_reg;
    end
  end
  wire bit_en = s2_reg[8];
  wire receive_positive_data = s2_reg[7];
  wire receive_negative_data = s2_reg[6];
  wire dfo = s2_reg[5];
  wire es_nov = s2_reg[4];
  wire es_nun = s2_reg[3];
  wire es_ov = s2_reg[2];
  wire es_un = s2_reg[1];
  wire pat_lock = s2_reg[0];

  // registers
  reg [7:0] cr1_reg;
  reg [7:0] cr2_reg;
  reg [7:0] cr3_reg;
  reg [7:0] icr_reg;
  reg [7:0] tsr_reg;
  reg [7:0] psr_reg;
  reg [7:0] cr4_reg;
  wire wr_cr1 = WR && ADDR == `LAM_ADDR_CR1;
  wire rd_tsr = RD && ADDR == `LAM_ADDR_TSR;
  wire e1_mode = cr1_reg[`LAM_CR1_EC_LSB+2:`LAM_CR1_EC_LSB] == `LAM_EC_E1;
  wire hdb3_on = cr1_reg[`LAM_CR1_ENC_BIT] && e1_mode;
  wire cv_on = hdb3_on && cr4_reg[`LAM_CR4_CODE_VIOLATION_DETECT_BIT];
  wire zv_on = hdb3_on && cr4_reg[`LAM_CR4_ZERO_SUBSTITUTION_VIOLATION_DETECT_BIT];
  wire bpv_on = !cr1_reg[`LAM_CR1_ENC_BIT];

  // bipolar line tracking
  reg last_pol_reg;
  reg last_viol_pol_reg;
  reg have_viol_reg;
  reg [2:0] zrun_reg;
  reg viol_next;
  wire mark = receive_positive_data ^ receive_negative_data;
  wire is_bpv = mark && (receive_positive_data == last_pol_reg);
  wire is_cv = is_bpv && have_viol_reg && (receive_positive_data == last_viol_pol_reg);
  wire is_zv = !mark && zrun_reg == `LAM_ZS_RUN - 3'd1;
  always @* begin
    viol_next = 1'b0;
    if (bit_en)
      viol_next = (bpv_on && is_bpv) || (cv_on && is_cv) || (zv_on && is_zv);
  end
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      last_pol_reg <= 1'b0;
      last_viol_pol_reg <= 1'b0;
      have_viol_reg <= 1'b0;
      zrun_reg <= 3'd0;
      LINE_VIOLATION_OUTPUT <= 1'b0;
      RX_DATA_POS <= 1'b0;
      RX_DATA_NEG <= 1'b0;
    end else begin
      LINE_VIOLATION_OUTPUT <= viol_next;
      if (bit_en) begin
        RX_DATA_POS <= receive_positive_data;
        RX_DATA_NEG <= receive_negative_data;
        if (mark) begin
          last_pol_reg <= receive_positive_data;
          zrun_reg <= 3'd0;
          if (is_bpv) begin
            last_viol_pol_reg <= receive_positive_data;
            have_viol_reg <= 1'b1;
          end
        end else if (zrun_reg != `LAM_ZS_RUN) begin
          zrun_reg <= zrun_reg + 3'd1;
        end
      end
    end
  end

  // loss of signal
  reg [11:0] zcnt_reg;
  reg los_reg;
  reg [127:0] win_reg;
  reg [7:0] ones_reg;
  reg [5:0] cm_reg;
  wire [11:0] los_thr = cr4_reg[`LAM_CR4_LONG_BIT] ? `LAM_LOS_LONG :
                        (e1_mode ? `LAM_LOS_E1 : `LAM_LOS_T1);
  wire old_bit = e1_mode ? win_reg[`LAM_E1_WIN-1] : win_reg[`LAM_T1_WIN-1];
  wire [7:0] ones_next = ones_reg + {7'd0, mark} - {7'd0, old_bit};
  wire [7:0] need = e1_mode ? `LAM_E1_MARKS : `LAM_T1_MARKS;
  wire [11:0] run_lim = e1_mode ? `LAM_E1_RUN : `LAM_T1_RUN;
  wire [11:0] zcnt_next = mark ? 12'd0 : (zcnt_reg == 12'hfff ? zcnt_reg : zcnt_reg + 12'd1);
  wire recover = (e1_mode && cr4_reg[`LAM_CR4_MARKS_BIT]) ? (mark && cm_reg == `LAM_CM_COUNT - 6'd1)
               : (ones_next >= need && zcnt_next < run_lim);
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      zcnt_reg <= 12'd0;
      los_reg <= 1'b0;
      win_reg <= 128'd0;
      ones_reg <= 8'd0;
      cm_reg <= 6'd0;
      CLOCK_SEL_MASTER <= 1'b0;
    end else begin
      CLOCK_SEL_MASTER <= los_reg;
      if (bit_en) begin
        zcnt_reg <= zcnt_next;
        win_reg <= {win_reg[126:0], mark};
        ones_reg <= ones_next;
        cm_reg <= mark ? (cm_reg == `LAM_CM_COUNT ? cm_reg : cm_reg + 6'd1) : 6'd0;
        if (!los_reg && zcnt_next >= los_thr)
          los_reg <= 1'b1;
        else if (los_reg && recover)
          los_reg <= 1'b0;
      end
    end
  end

  // AIS over fixed 2048-bit spans
  reg [11:0] span_reg;
  reg [1:0] aisz_reg;
  reg ais_reg;
  wire [1:0] aisz_next = (!mark && aisz_reg != `LAM_AIS_ZEROS) ? aisz_reg + 2'd1 : aisz_reg;
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      span_reg <= 12'd0;
      aisz_reg <= 2'd0;
      ais_reg <= 1'b0;
    end else if (bit_en) begin
      if (span_reg == `LAM_AIS_SPAN) begin
        span_reg <= 12'd0;
        aisz_reg <= 2'd0;
        ais_reg <= aisz_next != `LAM_AIS_ZEROS;
      end else begin
        span_reg <= span_reg + 12'd1;
        aisz_reg <= aisz_next;
      end
    end
  end

  // status, transitions, interrupt
  wire [7:0] psr_next = {1'b0, pat_lock & cr3_reg[`LAM_CR3_BIST_BIT], dfo, 1'b0, pat_lock, ais_reg, 1'b0, los_reg};
  wire [7:0] chg = (psr_next ^ psr_reg) & 8'h2d;
  wire [7:0] es_set = {es_un, es_ov, 6'd0};
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cr1_reg <= `LAM_REG_RESET;
      cr2_reg <= `LAM_REG_RESET;
      cr3_reg <= `LAM_REG_RESET;
      icr_reg <= `LAM_REG_RESET;
      cr4_reg <= `LAM_REG_RESET;
      tsr_reg <= `LAM_REG_RESET;
      psr_reg <= `LAM_REG_RESET;
      RDATA <= 8'h00;
      INT_N <= 1'b1;
      ES_PHASE_ADJ <= 2'd0;
      SELF_TEST_ON <= 1'b0;
    end else begin
      if (wr_cr1) cr1_reg <= WDATA;
      if (WR && ADDR == `LAM_ADDR_CR2) cr2_reg <= WDATA;
      if (WR && ADDR == `LAM_ADDR_CR3) cr3_reg <= WDATA;
      if (WR && ADDR == `LAM_ADDR_ICR) icr_reg <= WDATA;
      if (WR && ADDR == `LAM_ADDR_CR4) cr4_reg <= WDATA;
      psr_reg <= psr_next;
      // set wins over clear; a set clear bit among bits 0, 2, 3 and 5 drops the transition the cycle after it is flagged, even while the status holds
      tsr_reg <= (rd_tsr ? (tsr_reg & 8'h3f) : tsr_reg) & ~(icr_reg & 8'h2d) | chg | es_set;
      INT_N <= ~|(tsr_reg & ~icr_reg & 8'hed);
      ES_PHASE_ADJ <= {es_nov, es_nun};
      SELF_TEST_ON <= cr3_reg[`LAM_CR3_BIST_BIT];
      RDATA <= 8'h00;
      if (RD) begin
        case (ADDR)
          `LAM_ADDR_CR1: RDATA <= cr1_reg;
          `LAM_ADDR_CR2: RDATA <= cr2_reg;
          `LAM_ADDR_CR3: RDATA <= cr3_reg;
          `LAM_ADDR_ICR: RDATA <= icr_reg;
          `LAM_ADDR_TSR: RDATA <= tsr_reg;
          `LAM_ADDR_PSR: RDATA <= psr_reg;
          `LAM_ADDR_CR4: RDATA <= cr4_reg;
          default: RDATA <= 8'h00;
        endcase
      end
    end
  end
endmodule // lam_line_alarm_monitor
`default_nettype wire

// ==== sim/lam_props.sv ====
// port checker for the line alarm monitor
`timescale 1ns/1ps
`default_nettype none
module lam_props (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [5:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic RX_BIT_EN,
  input wire logic ES_NEAR_OVER_IN,
  input wire logic ES_NEAR_UNDER_IN,
  input wire logic LINE_VIOLATION_OUTPUT,
  input wire logic CLOCK_SEL_MASTER,
  input wire logic [1:0] ES_PHASE_ADJ,
  input wire logic INT_N,
  input wire logic SELF_TEST_ON
);
  wire [1:0] near = {ES_NEAR_OVER_IN, ES_NEAR_UNDER_IN};
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  AST_VIOL_CAUSE: assert property (LINE_VIOLATION_OUTPUT |-> $past(RX_BIT_EN, 3))
    else $error("violation pulse without a received bit");
  AST_RESET_VAL: assert property (disable iff (1'b0) $past(!RESETN) && !RESETN |-> INT_N && !CLOCK_SEL_MASTER
    && RDATA == 8'h00 && !LINE_VIOLATION_OUTPUT) else $error("outputs not cleared in reset");
  AST_LOSS_MOVE: assert property ($changed(CLOCK_SEL_MASTER) |-> $past(RX_BIT_EN, 3) || $past(RX_BIT_EN, 4))
    else $error("clock source moved without a received bit");
  AST_SELFTEST: assert property ($rose(SELF_TEST_ON) |-> $past(WR, 2) && $past(ADDR, 2) == 6'h12 && $past(WDATA[5], 2))
    else $error("self test started without control write");
  AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside the read answer cycle");
  AST_UNMAPPED: assert property (RD && ADDR == 6'h16 |=> RDATA == 8'h00)
    else $error("unmapped read returned data");
  AST_PHASE: assert property ($past(near, 2) == $past(near, 3) && $past(near, 3) == $past(near, 4)
    |-> ES_PHASE_ADJ == $past(near, 3)) else $error("phase adjust does not follow fill level");
  AST_INT_CLEAR: assert property ($rose(INT_N) |-> $past(WR, 2) || $past(RD, 2) || $past(WR, 3) || $past(RD, 3))
    else $error("interrupt released without host access");
endmodule // lam_props
bind lam_line_alarm_monitor lam_props u_props (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .RX_BIT_EN(RX_BIT_EN), .ES_NEAR_OVER_IN(ES_NEAR_OVER_IN),
  .ES_NEAR_UNDER_IN(ES_NEAR_UNDER_IN), .LINE_VIOLATION_OUTPUT(LINE_VIOLATION_OUTPUT),
  .CLOCK_SEL_MASTER(CLOCK_SEL_MASTER), .ES_PHASE_ADJ(ES_PHASE_ADJ), .INT_N(INT_N), .SELF_TEST_ON(SELF_TEST_ON));
`default_nettype wire

// ==== sim/lam_line_src.sv ====
// line side stand-in driving received bipolar symbols
`timescale 1ns/1ps
`default_nettype none
module lam_line_src (
  input wire logic CLK,
  output logic POS,
  output logic NEG,
  output logic EN
);
  initial begin
    POS = 1'b0;
    NEG = 1'b0;
    EN = 1'b0;
  end
  // code 0 zero, 1 positive mark, 2 negative mark
  task automatic sym(input logic [1:0] s);
    @(posedge CLK);
    EN <= 1'b1;
    POS <= s[0];
    NEG <= s[1];
  endtask
  // released rails toggle so no stale level survives
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge CLK);
      EN <= 1'b0;
      POS <= ~POS;
      NEG <= ~NEG;
    end
  endtask
endmodule // lam_line_src
`default_nettype wire

// ==== sim/lam_line_alarm_monitor_tb.sv ====
// self-checking bench for the line alarm monitor
`timescale 1ns/1ps
`default_nettype none
module lam_line_alarm_monitor_tb;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [5:0] ADDR = 6'h00;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic DRV = 1'b0;
  logic NOV = 1'b0;
  logic EOV = 1'b0;
  logic LCK = 1'b0;
  logic NUN = 1'b0;
  logic EUN = 1'b0;
  wire RXP, RXN;
  wire POS, NEG, EN, VIO, SEL, INTN, STO;
  wire [7:0] RDATA;
  wire [1:0] PH;
  int bad_count = 0;
  int tests_run = 0;
  int vcnt = 0;
  int v0;
  logic [5:0] amap [8] = '{6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h17, 6'h16};
  always #25 CLK = ~CLK;
  always @(posedge CLK) if (VIO === 1'b1) vcnt <= vcnt + 1;
  lam_line_src src (.CLK(CLK), .POS(POS), .NEG(NEG), .EN(EN));
  lam_line_alarm_monitor dut (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .RD_FLAG(RD), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .RX_BIT_EN(EN), .RECEIVE_POSITIVE_DATA(POS), .RECEIVE_NEGATIVE_DATA(NEG),
    .DRIVER_OPEN_IN(DRV), .ES_NEAR_OVER_IN(NOV), .ES_NEAR_UNDER_IN(NUN), .ES_OVER_IN(EOV), .ES_UNDER_IN(EUN),
    .PATTERN_LOCK_IN(LCK), .LINE_VIOLATION_OUTPUT(VIO), .RX_DATA_POS(RXP), .RX_DATA_NEG(RXN), .CLOCK_SEL_MASTER(SEL),
    .ES_PHASE_ADJ(PH), .INT_N(INTN), .SELF_TEST_ON(STO));
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic chb(input string n, input logic s, input logic e);
    chk(n, {7'h00, s}, {7'h00, e});
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk("rdata", RDATA, e);
  endtask
  task automatic wint(input logic e);
    for (int i = 0; i < 12 && INTN !== e; i++) @(posedge CLK);
    chb("int_n", INTN, e);
    if (INTN !== e) complete_run;
  endtask
  task automatic zeros(input int n);
    repeat (n) src.sym(2'd0);
  endtask
  initial begin
    #2000000;
    bad_count++;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge CLK);
    RESETN <= 1'b1;
    foreach (amap[i]) rd(amap[i], 8'h00);
    wr(6'h11, 8'h5a);
    rd(6'h11, 8'h5a);
    wr(6'h11, 8'h00);
    zeros(31);
    src.idle(6);
    chb("loss", SEL, 1'b0);
    zeros(1);
    src.idle(6);
    chb("loss", SEL, 1'b1);
    rd(6'h15, 8'h01);
    wint(1'b0);
    for (int i = 0; i < 40; i++) src.sym(i % 2 ? 2'd2 : 2'd1);
    src.idle(6);
    chb("loss", SEL, 1'b0);
    rd(6'h14, 8'h01);
    wr(6'h13, 8'h01);
    wint(1'b1);
    wr(6'h13, 8'h00);
    wr(6'h10, 8'h20);
    wr(6'h17, 8'h02);
    v0 = vcnt;
    src.sym(2'd1);
    zeros(4);
    src.idle(6);
    chk("zero_run", 8'(vcnt - v0), 8'h01);
    wr(6'h17, 8'h01);
    v0 = vcnt;
    src.sym(2'd2);
    src.sym(2'd2);
    src.sym(2'd1);
    src.sym(2'd2);
    src.sym(2'd2);
    src.idle(6);
    chk("code_viol", 8'(vcnt - v0), 8'h01);
    chb("rx_neg", RXN, 1'b1);
    chb("rx_pos", RXP, 1'b0);
    wr(6'h17, 8'h00);
    v0 = vcnt;
    zeros(5);
    src.idle(6);
    chk("gated", 8'(vcnt - v0), 8'h00);
    DRV <= 1'b1;
    wint(1'b0);
    rd(6'h15, 8'h20);
    rd(6'h14, 8'h20);
    DRV <= 1'b0;
    repeat (6) @(posedge CLK);
    wr(6'h13, 8'h20);
    wint(1'b1);
    wr(6'h13, 8'h00);
    EOV <= 1'b1;
    repeat (2) @(posedge CLK);
    EOV <= 1'b0;
    wint(1'b0);
    rd(6'h14, 8'h40);
    rd(6'h14, 8'h00);
    wint(1'b1);
    EUN <= 1'b1;
    repeat (2) @(posedge CLK);
    EUN <= 1'b0;
    wint(1'b0);
    rd(6'h14, 8'h80);
    wint(1'b1);
    wr(6'h12, 8'h20);
    LCK <= 1'b1;
    repeat (5) @(posedge CLK);
    rd(6'h15, 8'h48);
    chb("self_test", STO, 1'b1);
    NOV <= 1'b1;
    repeat (6) @(posedge CLK);
    chk("phase", {6'h00, PH}, 8'h02);
    NUN <= 1'b1;
    repeat (6) @(posedge CLK);
    chk("phase", {6'h00, PH}, 8'h03);
    complete_run;
  end
endmodule // lam_line_alarm_monitor_tb
`default_nettype wire
